// ### core/tplc_touch_probe_latch.sv
`timescale 1ns/1ps
`include "tplc_defs.svh"

module tplc_touch_probe_latch
	import tplc_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Register port
	input  wire logic [3:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata,
	// Trigger sources
	input  wire logic        i_external_latch_input_one,
	input  wire logic        i_external_latch_input_two,
	input  wire logic        i_home_position_output,
	input  wire logic        i_timing_output,
	// Latch strobes and state
	output logic      [1:0]  o_latch,
	output logic      [1:0]  o_done
);

	logic [15:0]           cfg_q;
	tplc_probe_cfg_t [1:0] pcfg;
	logic [1:0]            ext_src;
	logic                  int_src;
	logic [1:0]            trig;
	logic [1:0]            trig_q;
	logic [1:0]            fire;
	logic [1:0]            done_q;

	// Home and timing outputs share one source select
	assign int_src = i_home_position_output | i_timing_output;
	assign ext_src = {i_external_latch_input_two, i_external_latch_input_one};

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cfg_q <= `TPLC_CFG_RST;
		end else if (i_wr && i_addr == `TPLC_CFG_ADDR) begin
			cfg_q <= i_wdata & `TPLC_CFG_MASK;
		end
	end

	assign pcfg[0].fall_en = cfg_q[`TPLC_P1_FALL_BIT];
	assign pcfg[0].rise_en = cfg_q[`TPLC_P1_RISE_BIT];
	assign pcfg[0].src_sel = cfg_q[`TPLC_P1_SRC_BIT];
	assign pcfg[0].cont    = cfg_q[`TPLC_P1_CONT_BIT];
	assign pcfg[0].enable  = cfg_q[`TPLC_P1_EN_BIT];
	assign pcfg[1].fall_en = cfg_q[`TPLC_P2_FALL_BIT];
	assign pcfg[1].rise_en = cfg_q[`TPLC_P2_RISE_BIT];
	assign pcfg[1].src_sel = cfg_q[`TPLC_P2_SRC_BIT];
	assign pcfg[1].cont    = cfg_q[`TPLC_P2_CONT_BIT];
	assign pcfg[1].enable  = cfg_q[`TPLC_P2_EN_BIT];

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_probe
			assign trig[g] = pcfg[g].src_sel ? int_src : ext_src[g];
			// edge qualification
			// Combinational so the strobe lands one cycle after
			assign fire[g] = pcfg[g].enable &&
				(pcfg[g].cont || !done_q[g]) &&
				((pcfg[g].rise_en && trig[g] && !trig_q[g]) ||
				 (pcfg[g].fall_en && !trig[g] && trig_q[g]));

			// Config resets disabled, so a high pin cannot latch
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					trig_q[g] <= 1'b0;
				end else begin
					trig_q[g] <= trig[g];
				end
			end

			// single shot lockout, rearmed while disabled
			// Continuous mode drops a stale lockout
			always_ff @(posedge i_clk) begin
				if (i_rst || !pcfg[g].enable || pcfg[g].cont) begin
					done_q[g] <= 1'b0;
				end else if (fire[g]) begin
					done_q[g] <= 1'b1;
				end
			end

			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					o_latch[g] <= 1'b0;
				end else begin
					o_latch[g] <= fire[g];
				end
			end

			AST_ONCE: assert property (
				@(posedge i_clk) disable iff (i_rst)
				fire[g] && !pcfg[g].cont ##1 pcfg[g].enable ##0
				$stable(cfg_q) |-> !fire[g])
				else $error("single shot probe latched twice");
			AST_LOCK: assert property (
				@(posedge i_clk) disable iff (i_rst)
				fire[g] && !pcfg[g].cont |=> done_q[g])
				else $error("single shot lock not set");
			AST_CONT: assert property (
				@(posedge i_clk) disable iff (i_rst)
				pcfg[g].cont |=> !done_q[g])
				else $error("continuous probe locked");
			AST_EDGE: assert property (
				@(posedge i_clk) disable iff (i_rst)
				fire[g] |-> (trig[g] ? pcfg[g].rise_en : pcfg[g].fall_en)
				&& trig[g] != trig_q[g])
				else $error("latch on disabled edge");
			AST_RISE: assert property (
				@(posedge i_clk) disable iff (i_rst)
				pcfg[g].enable && pcfg[g].rise_en && !done_q[g] &&
				trig[g] && !trig_q[g] |=> o_latch[g])
				else $error("rising edge missed");
			AST_FALL: assert property (
				@(posedge i_clk) disable iff (i_rst)
				pcfg[g].enable && pcfg[g].fall_en && !done_q[g] &&
				!trig[g] && trig_q[g] |=> o_latch[g])
				else $error("falling edge missed");
			AST_OFF: assert property (
				@(posedge i_clk) disable iff (i_rst)
				!pcfg[g].enable |=> !o_latch[g])
				else $error("disabled probe latched");
			AST_PULSE: assert property (
				@(posedge i_clk) disable iff (i_rst)
				o_latch[g] == $past(fire[g]))
				else $error("latch strobe misaligned");
			// external select ignores home and timing
			AST_SRC: assert property (
				@(posedge i_clk) disable iff (i_rst)
				$stable(cfg_q) && !pcfg[g].src_sel &&
				$stable(ext_src[g]) |-> !fire[g])
				else $error("latch without external edge");
			AST_SRC_INT: assert property (
				@(posedge i_clk) disable iff (i_rst)
				$stable(cfg_q) && pcfg[g].src_sel &&
				$stable(int_src) |-> !fire[g])
				else $error("latch without internal edge");
		end
	endgenerate

	// Done flags reported for software
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_done <= 2'h0;
		end else begin
			o_done <= done_q;
		end
	end

	// Status word is read-only; writes to it are dropped
	// Read port, unmapped reads zero
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata <= 16'h0000;
		end else if (i_rd && i_addr == `TPLC_CFG_ADDR) begin
			o_rdata <= cfg_q;
		end else if (i_rd && i_addr == `TPLC_STAT_ADDR) begin
			o_rdata <= {14'h0000, done_q};
		end else begin
			o_rdata <= 16'h0000;
		end
	end

	AST_RSVD: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(cfg_q & ~`TPLC_CFG_MASK) == 16'h0000)
		else $error("reserved bits stored");
	AST_WR: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_wr && i_addr == `TPLC_CFG_ADDR |=>
		cfg_q == ($past(i_wdata) & `TPLC_CFG_MASK))
		else $error("configuration write lost");
	AST_RD_CFG: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == `TPLC_CFG_ADDR |=> o_rdata == $past(cfg_q))
		else $error("configuration readback wrong");
	AST_RD_STAT: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == `TPLC_STAT_ADDR |=>
		o_rdata == {14'h0000, $past(done_q)})
		else $error("status readback wrong");
	AST_DONE: assert property (
		@(posedge i_clk) disable iff (i_rst)
		o_done == $past(done_q))
		else $error("done flag misaligned");

endmodule : tplc_touch_probe_latch

// ### include/tplc_defs.svh
`ifndef TPLC_DEFS_SVH
`define TPLC_DEFS_SVH

// Configuration word offset and field positions
`define TPLC_CFG_ADDR      4'h0
`define TPLC_STAT_ADDR     4'h1
`define TPLC_CFG_RST       16'h0000
`define TPLC_P1_EN_BIT     0
`define TPLC_P1_CONT_BIT   1
`define TPLC_P1_SRC_BIT    2
`define TPLC_P1_RISE_BIT   4
`define TPLC_P1_FALL_BIT   5
`define TPLC_P2_EN_BIT     8
`define TPLC_P2_CONT_BIT   9
`define TPLC_P2_SRC_BIT    10
`define TPLC_P2_RISE_BIT   12
`define TPLC_P2_FALL_BIT   13
`define TPLC_CFG_MASK      16'h3737

`endif

// ### include/tplc_pkg.sv
package tplc_pkg;
	typedef struct packed {
		logic fall_en;
		logic rise_en;
		logic src_sel;
		logic cont;
		logic enable;
	} tplc_probe_cfg_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [15:0] wdata;
	} tplc_bus_req_t;
endpackage : tplc_pkg

// ### verification/touch_probe_latch_control_tb_top.sv
`timescale 1ns/1ps
module touch_probe_latch_control_tb_top;
	logic        clk = 0, rst = 1, gw = 0, gr = 0, wr, rd;
	logic [3:0]  sel = 4'h0, trig = 4'h0, addr;
	logic [15:0] wd = 16'h0000, n1, n2, rdata, wdata;
	logic [1:0]  lat, done;
	int          err_count = 0, checks_done = 0, k;
	logic [15:0] cf [12] = '{16'h0000, 16'h0003, 16'h0013, 16'h0021,
		16'h0037, 16'h0037, 16'h0037, 16'h3300, 16'h3700, 16'h1100,
		16'h0000, 16'h2100};
	int tb [12] = '{0, 0, 0, 0, 0, 2, 3, 1, 3, 1, 1, 1};
	int nf [12] = '{2, 2, 3, 3, 2, 2, 2, 2, 2, 4, 2, 4};
	int e1 [12] = '{0, 0, 2, 1, 0, 2, 2, 0, 0, 0, 0, 0};
	int e2 [12] = '{0, 0, 0, 0, 0, 0, 0, 2, 2, 1, 0, 1};
	always #20 clk = ~clk;
	// Pulse counters, cleared by each write
	always @(posedge clk) begin
		if (rst || wr) begin
			n1 <= 16'h0000;
			n2 <= 16'h0000;
		end else begin
			n1 <= n1 + 16'(lat[0]);
			n2 <= n2 + 16'(lat[1]);
		end
	end
	tplc_master_model u_tplc_master_model (.i_clk(clk), .i_go_wr(gw),
		.i_go_rd(gr), .i_sel(sel), .i_word(wd), .o_wr(wr), .o_rd(rd),
		.o_addr(addr), .o_wdata(wdata));
	tplc_touch_probe_latch u_tplc_touch_probe_latch (.i_clk(clk),
		.i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_external_latch_input_one(trig[0]),
		.i_external_latch_input_two(trig[1]), .i_home_position_output(trig[2]),
		.i_timing_output(trig[3]), .o_latch(lat), .o_done(done));
	task chk(input string nm, input logic [15:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task wrc(input logic [15:0] v);
		@(posedge clk) begin gw <= 1'b1; wd <= v; sel <= 4'h0; end
		@(posedge clk) gw <= 1'b0;
		@(posedge clk);
	endtask : wrc
	task rdc(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk) begin gr <= 1'b1; sel <= a; end
		@(posedge clk) gr <= 1'b0;
		@(posedge clk) #1;
		chk("rdata", exp, rdata);
	endtask : rdc
	task end_sim;
		if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	// Hang guard counts as a mismatch
	initial begin #1000000; err_count++; end_sim; end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		for (k = 0; k < 12; k++) begin
			if (k > 0) wrc(cf[k]);
			repeat (nf[k]) begin
				@(posedge clk) trig[tb[k]] <= ~trig[tb[k]];
				repeat (3) @(posedge clk);
			end
			chk("latch one", 16'(e1[k]), n1);
			chk("latch two", 16'(e2[k]), n2);
		end
		// Single shot flag, readback, unmapped
		rdc(4'h1, 16'h0002);
		chk("done", 16'h0002, {14'h0000, done});
		wrc(16'h1337);
		rdc(4'h0, 16'h1337);
		rdc(4'h5, 16'h0000);
		end_sim;
	end
endmodule : touch_probe_latch_control_tb_top

// ### verification/tplc_master_model.sv
`timescale 1ns/1ps
`include "tplc_defs.svh"
module tplc_master_model (
	// Bench commands
	input  wire logic        i_clk,
	input  wire logic        i_go_wr,
	input  wire logic        i_go_rd,
	input  wire logic [3:0]  i_sel,
	input  wire logic [15:0] i_word,
	// Register port
	output logic             o_wr,
	output logic             o_rd,
	output logic      [3:0]  o_addr,
	output logic      [15:0] o_wdata
);
	always_ff @(posedge i_clk) begin
		o_wr    <= i_go_wr;
		o_rd    <= i_go_rd;
		o_addr  <= i_sel;
		o_wdata <= i_word & `TPLC_CFG_MASK;
	end
endmodule : tplc_master_model
